// ===== hdl/csp_regs.svh
/*
  Register indices, field positions, reset values and timing counts of the
  clock source and PLL configuration block.
  Assumes a 25 MHz system clock; byte address of a register is four times its index.
*/
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define CSP_IDX_PLL_CTRL    12'h010
`define CSP_IDX_CAL_CTRL    12'h018
`define CSP_IDX_DIV_RATIO   12'h1E0
`define CSP_IDX_DIST_SEL    12'h1E1
`define CSP_IDX_UPDATE      12'h232
`define CSP_IDX_STATUS      12'h233

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define CSP_PLL_PWR_LSB     0
`define CSP_PLL_PWR_MSB     1
`define CSP_PFD_POL_BIT     7
`define CSP_CAL_BIT         0
`define CSP_DIV_LSB         0
`define CSP_DIV_MSB         2
`define CSP_BYPASS_BIT      0
`define CSP_SRC_VCO_BIT     1
`define CSP_UPDATE_BIT      0
`define CSP_PWR_NORMAL      2'h0
`define CSP_PWR_DOWN        2'h1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSP_RST_PLL_CTRL    8'h01
`define CSP_RST_CAL_CTRL    8'h00
`define CSP_RST_DIV_RATIO   8'h02
`define CSP_RST_DIST_SEL    8'h00
`define CSP_RST_DIV_VALUE   3'h4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CSP_CLK_PERIOD_NS   40
`define CSP_CAL_TIME_NS     4000
`define CSP_CAL_CYCLES      ((`CSP_CAL_TIME_NS + `CSP_CLK_PERIOD_NS - 1) / `CSP_CLK_PERIOD_NS)

`endif

// ===== hdl/csp_pkg.sv
/*
  Types of the clock source and PLL configuration block.
  Assumes nothing beyond the register header.
*/
package csp_pkg;

  typedef enum logic [1:0] {
    CSP_CAL_IDLE,
    CSP_CAL_RUN,
    CSP_CAL_DONE
  } csp_cal_state_t;

  typedef struct packed {
    csp_cal_state_t state;
    logic [15:0]    cnt;
    logic           busy;
    logic           done;
  } csp_cal_t;

  typedef struct packed {
    logic [7:0]  pll_buf;
    logic [7:0]  cal_buf;
    logic [7:0]  div_buf;
    logic [7:0]  sel_buf;
    logic        pll_off;
    logic        pfd_neg;
    logic        cal_bit;
    logic [2:0]  div_ratio;
    logic        bypass;
    logic        src_vco;
    logic        upd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } csp_state_t;

endpackage : csp_pkg

// ===== hdl/csp_vco_cal.sv
/*
  VCO calibration sequencer: one run per start, re-armed only by a clear.
  Assumes start and clear are one-cycle pulses that never coincide.
*/
`timescale 1ns/10ps
`include "csp_regs.svh"

module csp_vco_cal
  import csp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic clear_i,
  output logic      busy_o,
  output logic      done_o
);

  csp_cal_t s;
  csp_cal_t next_s;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    case (s.state)
      CSP_CAL_IDLE: begin
        if (start_i) begin
          next_s.state = CSP_CAL_RUN;
          next_s.cnt   = 16'(`CSP_CAL_CYCLES - 1);
          next_s.busy  = 1'b1;
        end
      end
      CSP_CAL_RUN: begin
        if (s.cnt == 16'h0000) begin
          next_s.state = CSP_CAL_DONE;
          next_s.busy  = 1'b0;
          next_s.done  = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      CSP_CAL_DONE: begin
        next_s.state = CSP_CAL_DONE;
      end
      default: begin
        next_s.state = CSP_CAL_IDLE;
      end
    endcase
    // Clear aborts a run too, so a fresh start always sees a reset engine
    if (clear_i) begin
      next_s.state = CSP_CAL_IDLE;
      next_s.cnt   = 16'h0000;
      next_s.busy  = 1'b0;
      next_s.done  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s <= '{state: CSP_CAL_IDLE, cnt: 16'h0000, busy: 1'b0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_cal_finish: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.state == CSP_CAL_RUN && s.cnt == 16'h0000 && !clear_i) |=> (done_o && !busy_o))
    else $error("calibration did not finish at end of count");

  a_cal_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clear_i |=> (!busy_o && !done_o && s.state == CSP_CAL_IDLE))
    else $error("calibration clear did not reset the engine");

endmodule : csp_vco_cal

// ===== hdl/csp_top.sv
/*
  Clock source selection and PLL configuration registers with an APB slave,
  buffered settings and an update strobe that makes them active.
  Assumes an APB master on CLK_I and analog blocks that follow the outputs.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "csp_regs.svh"

module csp_top
  import csp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             PLL_OFF_O,
  output logic             PFD_NEG_O,
  output logic             SRC_VCO_O,
  output logic             DIV_BYPASS_O,
  output logic      [2:0]  DIV_RATIO_O,
  output logic             UPDATE_O,
  output logic             CAL_BUSY_O,
  output logic             CAL_DONE_O
);

  localparam csp_state_t RESET_STATE = '{
    pll_buf:   `CSP_RST_PLL_CTRL,
    cal_buf:   `CSP_RST_CAL_CTRL,
    div_buf:   `CSP_RST_DIV_RATIO,
    sel_buf:   `CSP_RST_DIST_SEL,
    pll_off:   1'b1,
    pfd_neg:   1'b0,
    cal_bit:   1'b0,
    div_ratio: `CSP_RST_DIV_VALUE,
    bypass:    1'b0,
    src_vco:   1'b0,
    upd:       1'b0,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h0000_0000
  };

  csp_state_t  s;
  csp_state_t  next_s;
  logic        setup_ph;
  logic        done_ph;
  logic [11:0] word;
  logic        hit;
  logic        upd_fire;
  logic        cal_go;
  logic        cal_clr;
  logic        cal_busy;
  logic        cal_done;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Slave answers in the first access cycle; low two address bits ignored
  assign setup_ph = PSEL_I && !PENABLE_I;
  assign done_ph  = PSEL_I && PENABLE_I && s.pready;
  assign word     = {2'h0, PADDR_I[11:2]};
  assign hit      = (word == `CSP_IDX_PLL_CTRL)  || (word == `CSP_IDX_CAL_CTRL) ||
                    (word == `CSP_IDX_DIV_RATIO) || (word == `CSP_IDX_DIST_SEL) ||
                    (word == `CSP_IDX_UPDATE)    || (word == `CSP_IDX_STATUS);
  assign upd_fire = done_ph && PWRITE_I && (word == `CSP_IDX_UPDATE) &&
                    PWDATA_I[`CSP_UPDATE_BIT];
  // Start only from the cleared state, so a stale 1 never retriggers
  assign cal_go   = upd_fire && s.cal_buf[`CSP_CAL_BIT] && !s.cal_bit;
  assign cal_clr  = upd_fire && !s.cal_buf[`CSP_CAL_BIT];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.upd     = 1'b0;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (setup_ph) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata  = 32'h0000_0000;
      case (word)
        `CSP_IDX_PLL_CTRL:  next_s.prdata[7:0] = s.pll_buf;
        `CSP_IDX_CAL_CTRL:  next_s.prdata[7:0] = s.cal_buf;
        `CSP_IDX_DIV_RATIO: next_s.prdata[7:0] = s.div_buf;
        `CSP_IDX_DIST_SEL:  next_s.prdata[7:0] = s.sel_buf;
        `CSP_IDX_STATUS:    next_s.prdata[10:0] = {s.div_ratio, 2'h0, s.src_vco,
                                                   s.bypass, s.pfd_neg, s.pll_off,
                                                   cal_done, cal_busy};
        default:            next_s.prdata = 32'h0000_0000;
      endcase
    end
    if (done_ph && PWRITE_I) begin
      case (word)
        `CSP_IDX_PLL_CTRL:  next_s.pll_buf = PWDATA_I[7:0];
        `CSP_IDX_CAL_CTRL:  next_s.cal_buf = PWDATA_I[7:0];
        `CSP_IDX_DIV_RATIO: next_s.div_buf = PWDATA_I[7:0];
        `CSP_IDX_DIST_SEL:  next_s.sel_buf = PWDATA_I[7:0];
        default:            next_s.upd = 1'b0;
      endcase
    end
    if (upd_fire) begin
      next_s.upd     = 1'b1;
      // Only code 00b runs the loop; spare codes fail safe to off
      next_s.pll_off = s.pll_buf[`CSP_PLL_PWR_MSB:`CSP_PLL_PWR_LSB]
                       != `CSP_PWR_NORMAL;
      next_s.pfd_neg = s.pll_buf[`CSP_PFD_POL_BIT];
      next_s.cal_bit = s.cal_buf[`CSP_CAL_BIT];
      next_s.bypass  = s.sel_buf[`CSP_BYPASS_BIT];
      next_s.src_vco = s.sel_buf[`CSP_SRC_VCO_BIT];
      case (s.div_buf[`CSP_DIV_MSB:`CSP_DIV_LSB])
        3'h0:    next_s.div_ratio = 3'h2;
        3'h1:    next_s.div_ratio = 3'h3;
        3'h2:    next_s.div_ratio = 3'h4;
        3'h3:    next_s.div_ratio = 3'h5;
        // Unused codes clamp to the largest ratio, keeping channel inputs low
        default: next_s.div_ratio = 3'h6;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Calibration engine
  // --------------------------------------------------------------------------
  csp_vco_cal u_cal (
    .clk_i   (CLK_I),
    .nrst_i  (NRST_I),
    .start_i (cal_go),
    .clear_i (cal_clr),
    .busy_o  (cal_busy),
    .done_o  (cal_done)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign PRDATA_O     = s.prdata;
  assign PREADY_O     = s.pready;
  assign PSLVERR_O    = s.pslverr;
  assign PLL_OFF_O    = s.pll_off;
  assign PFD_NEG_O    = s.pfd_neg;
  assign SRC_VCO_O    = s.src_vco;
  assign DIV_BYPASS_O = s.bypass;
  assign DIV_RATIO_O  = s.div_ratio;
  assign UPDATE_O     = s.upd;
  assign CAL_BUSY_O   = cal_busy;
  assign CAL_DONE_O   = cal_done;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_pll_down_code: assert property (
    upd_fire && s.pll_buf[1:0] == 2'h1 |=> PLL_OFF_O)
    else $error("power-down code did not stop the PLL");

  a_pll_run_code: assert property (
    upd_fire && s.pll_buf[1:0] == 2'h0 |=> !PLL_OFF_O)
    else $error("normal code did not run the PLL");

  a_bypass_load: assert property (
    upd_fire |=> DIV_BYPASS_O == $past(s.sel_buf[0]))
    else $error("bypass bit not applied on update");

  a_src_load: assert property (
    upd_fire |=> SRC_VCO_O == $past(s.sel_buf[1]))
    else $error("source select not applied on update");

  a_div_ratio_map: assert property (
    upd_fire && s.div_buf[2:0] <= 3'h4 |=> DIV_RATIO_O == $past(s.div_buf[2:0]) + 3'h2)
    else $error("divider ratio mismatch");

  a_cal_launch: assert property (
    cal_go |=> CAL_BUSY_O ##1 CAL_BUSY_O)
    else $error("calibration did not start after update");

  a_hold_until_upd: assert property (
    !upd_fire |=> $stable({PLL_OFF_O, PFD_NEG_O, SRC_VCO_O, DIV_BYPASS_O, DIV_RATIO_O}))
    else $error("active setting changed without update");

  a_pfd_pol_load: assert property (
    upd_fire |=> PFD_NEG_O == $past(s.pll_buf[7]))
    else $error("polarity not applied on update");

  a_upd_single: assert property (
    UPDATE_O |=> !UPDATE_O)
    else $error("update pulse longer than one cycle");

  a_reset_dflt: assert property (
    $past(!NRST_I) |-> PLL_OFF_O && !SRC_VCO_O && !DIV_BYPASS_O && DIV_RATIO_O == 3'h4)
    else $error("reset defaults wrong");

endmodule : csp_top

// ===== dv/tb_top.sv
/*
  Self-checking testbench of the clock source and PLL configuration block.
  Assumes csp_pkg and csp_regs.svh are compiled first; the bench is the APB master.
*/
`timescale 1ns/10ps
`include "csp_regs.svh"

module tb_top;

  // --------------------------------------------------------------------------
  // Signals and design
  // --------------------------------------------------------------------------
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pll_off;
  logic        pfd_neg;
  logic        src_vco;
  logic        div_bypass;
  logic [2:0]  div_ratio;
  logic        update;
  logic        cal_busy;
  logic        cal_done;
  int          bad_count;
  int          compares;

  csp_top i_csp_top (
    .CLK_I        (clk),
    .NRST_I       (nrst),
    .PSEL_I       (psel),
    .PENABLE_I    (penable),
    .PWRITE_I     (pwrite),
    .PADDR_I      (paddr),
    .PWDATA_I     (pwdata),
    .PRDATA_O     (prdata),
    .PREADY_O     (pready),
    .PSLVERR_O    (pslverr),
    .PLL_OFF_O    (pll_off),
    .PFD_NEG_O    (pfd_neg),
    .SRC_VCO_O    (src_vco),
    .DIV_BYPASS_O (div_bypass),
    .DIV_RATIO_O  (div_ratio),
    .UPDATE_O     (update),
    .CAL_BUSY_O   (cal_busy),
    .CAL_DONE_O   (cal_done)
  );

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    check("ready wait", 32'(n), 32'h1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, data, d, e);
  endtask : wr

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0, d, e);
    check(what, d, exp);
  endtask : rd

  // Update strobe, then one edge so the new active values are visible
  task automatic upd();
    wr(12'h8C8, 32'h1);
    @(posedge clk);
  endtask : upd

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    check("pll off", pll_off, 32'h1);
    check("source vco", src_vco, 32'h0);
    check("bypass", div_bypass, 32'h0);
    check("ratio", div_ratio, 32'h4);
    rd(12'h040, 32'h01, "pll ctrl");
    rd(12'h780, 32'h02, "div ratio reg");
    rd(12'h784, 32'h00, "dist sel reg");
  endtask : t_reset

  task automatic t_buffered();
    wr(12'h040, 32'h80);
    wr(12'h780, 32'h0);
    wr(12'h784, 32'h1);
    rd(12'h040, 32'h80, "pll ctrl back");
    check("pll off held", pll_off, 32'h1);
    wr(12'h8C8, 32'h0);
    @(posedge clk);
    check("no update on 0", div_bypass, 32'h0);
    upd();
    check("update pulse", update, 32'h1);
    check("pll on", pll_off, 32'h0);
    check("pfd negative", pfd_neg, 32'h1);
    check("source ext", src_vco, 32'h0);
    check("bypass set", div_bypass, 32'h1);
    check("ratio 2", div_ratio, 32'h2);
    @(posedge clk);
    check("update ends", update, 32'h0);
    rd(12'h8C8, 32'h0, "update readback");
    wr(12'h040, 32'h01);
    wr(12'h784, 32'h2);
    upd();
    check("pll off", pll_off, 32'h1);
    check("pfd positive", pfd_neg, 32'h0);
    check("source vco", src_vco, 32'h1);
    check("bypass clr", div_bypass, 32'h0);
  endtask : t_buffered

  task automatic t_divider();
    // Spare codes 5 to 7 clamp to the largest ratio
    for (int c = 0; c < 8; c++) begin
      wr(12'h780, 32'(c));
      upd();
      check("ratio", div_ratio, (c < 5) ? 32'(c + 2) : 32'h6);
    end
  endtask : t_divider

  task automatic t_cal();
    int n;
    wr(12'h060, 32'h1);
    upd();
    n = 0;
    while (cal_busy === 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
    end
    check("busy cycles", 32'(n), 32'(`CSP_CAL_CYCLES));
    check("cal done", cal_done, 32'h1);
    rd(12'h8CC, 32'h626, "status");
    upd();
    check("no rerun armed", cal_busy, 32'h0);
    wr(12'h060, 32'h0);
    upd();
    check("done cleared", cal_done, 32'h0);
    wr(12'h060, 32'h1);
    upd();
    check("rerun busy", cal_busy, 32'h1);
  endtask : t_cal

  // Unmapped place: error response, nothing read back
  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    apb(1'b1, 12'h100, 32'hFF, d, e);
    check("write error", e, 32'h1);
    apb(1'b0, 12'h100, 32'h0, d, e);
    check("read error", e, 32'h1);
    check("read zero", d, 32'h0);
  endtask : t_unmapped

  // --------------------------------------------------------------------------
  // Clock, sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_buffered();
    t_divider();
    t_cal();
    t_unmapped();
    report_and_stop();
  end

  // Whole run needs well under 1000 cycles; generous margin
  initial begin
    #(40 * 20000);
    bad_count++;
    $display("unexpected watchdog expected end seen hang");
    report_and_stop();
  end

endmodule : tb_top
